// ===== src/agp_top.sv
// general-purpose pin port: input sync, pin registers, pin drivers
//
// Behaviour
// - Direction bits 7:4: 0 drives a digital pin (function bit 1) as output, 1 makes it input; reset 0.
// - Level bits 3:0 set output level; reads return sampled level for digital inputs.
// - Function bits: 0 routes pin to analog mux, 1 makes it digital; reset 0.
// - Function bit x steers pin x alone, one bit per pin.
// - Register access uses serial mode 1: clock polarity 0, clock phase 1.
// - Serial clock idles low; data launched on rises, sampled on falls.
`timescale 1ns/1ps
`default_nettype none
module agp_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe_n,
   output logic [3:0] pin_analog_sel
);
   // two-flop synchronisers for every pin input
   logic [6:0] sync1_q, sync1_d, sync2_q, sync2_d;
   logic sclk_s, cs_n_s, mosi_s;
   logic [3:0] pin_s;

   always_comb begin
      sync1_d = {spi_sclk, spi_cs_n, spi_mosi, gpio_in};
      sync2_d = sync1_q;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync1_q <= agp_pkg::AGP_SYNC_RST;
         sync2_q <= agp_pkg::AGP_SYNC_RST;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   assign sclk_s = sync2_q[6];
   assign cs_n_s = sync2_q[5];
   assign mosi_s = sync2_q[4];
   assign pin_s = sync2_q[3:0];

   agp_reg_if bus ();

   agp_spi_engine u_engine (
      .sys_clk (sys_clk),
      .rst_n (rst_n),
      .sclk_s (sclk_s),
      .cs_n_s (cs_n_s),
      .mosi_s (mosi_s),
      .miso (spi_miso),
      .miso_oe_n (spi_miso_oe_n),
      .bus (bus)
   );

   // pin register state and registered pin controls
   logic [3:0] dir_q, dir_d, level_q, level_d, func_q, func_d;
   logic [3:0] oe_n_q, oe_n_d, analog_q, analog_d;
   logic [3:0] level_view;

   // the level a read shows: live pin for digital inputs, stored bit otherwise
   function automatic logic [3:0] agp_level_view(input logic [3:0] func, input logic [3:0] dir,
                                                 input logic [3:0] stored, input logic [3:0] pins);
      logic [3:0] v;
      v = stored;
      for (int i = 0; i < 4; i++) begin
         if (func[i] && dir[i]) begin
            v[i] = pins[i];
         end
      end
      return v;
   endfunction

   assign level_view = agp_level_view(func_q, dir_q, level_q, pin_s);

   // register writes; unmapped addresses are dropped silently
   always_comb begin
      dir_d = dir_q;
      level_d = level_q;
      func_d = func_q;
      if (bus.wr) begin
         unique case (bus.addr)
            agp_pkg::AGP_ADDR_DIR_LEVEL: begin
               dir_d = bus.wdata[agp_pkg::AGP_DIR_LSB +: 4];
               // stored even for inputs, so a later switch to output is glitch free
               level_d = bus.wdata[agp_pkg::AGP_LEVEL_LSB +: 4];
            end
            agp_pkg::AGP_ADDR_FUNC_SEL: begin
               func_d = bus.wdata[agp_pkg::AGP_FUNC_LSB +: 4];
            end
            default: begin
               func_d = func_q;
            end
         endcase
      end
      // per-pin control, bit x only touches pin x
      oe_n_d = ~(func_d & ~dir_d);
      analog_d = ~func_d;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dir_q <= agp_pkg::AGP_RST_DIR;
         level_q <= agp_pkg::AGP_RST_LEVEL;
         func_q <= agp_pkg::AGP_RST_FUNC;
         oe_n_q <= agp_pkg::AGP_RST_OE_N;
         analog_q <= agp_pkg::AGP_RST_ANALOG;
      end else begin
         dir_q <= dir_d;
         level_q <= level_d;
         func_q <= func_d;
         oe_n_q <= oe_n_d;
         analog_q <= analog_d;
      end
   end

   // read view; upper nibble of function register is hardwired zero
   always_comb begin
      unique case (bus.addr)
         agp_pkg::AGP_ADDR_DIR_LEVEL: bus.rdata = {dir_q, level_view};
         agp_pkg::AGP_ADDR_FUNC_SEL: bus.rdata = {agp_pkg::AGP_RSVD_READ, func_q};
         default: bus.rdata = agp_pkg::AGP_UNMAPPED_READ;
      endcase
   end

   // a disabled output still holds its level so the pad sees it when enabled
   assign gpio_out = level_q;
   assign gpio_oe_n = oe_n_q;
   assign pin_analog_sel = analog_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_dir_write;
      bus.wr && bus.addr == agp_pkg::AGP_ADDR_DIR_LEVEL;
   endsequence

   sequence s_func_write;
      bus.wr && bus.addr == agp_pkg::AGP_ADDR_FUNC_SEL;
   endsequence

   a_reset_all_zero: assert property (@(posedge sys_clk) disable iff (1'b0)
      !rst_n |=> dir_q == 4'h0 && func_q == 4'h0 && gpio_out == 4'h0 && gpio_oe_n == 4'hF)
      else $error("pin registers not cleared by reset");
   a_dir_write_lands: assert property (s_dir_write |=> dir_q == $past(bus.wdata[7:4]))
      else $error("direction bits did not take the written value");
   a_level_drives_pin: assert property (s_dir_write ##1 !bus.wr |=>
      gpio_out == $past(bus.wdata[3:0], 2))
      else $error("output level does not follow the written level bits");
   a_input_readback: assert property (bus.addr == agp_pkg::AGP_ADDR_DIR_LEVEL && func_q[0]
      && dir_q[0] |-> bus.rdata[0] == pin_s[0])
      else $error("input pin read does not show the sampled level");
   a_func_selects: assert property (s_func_write |=> pin_analog_sel == ~$past(bus.wdata[3:0]))
      else $error("analog routing does not follow the function bits");
   a_pin_drive_map: assert property (gpio_oe_n == ~(func_q & ~dir_q))
      else $error("pin driver enable not mapped bit for bit");
   a_reserved_zero: assert property (bus.addr == agp_pkg::AGP_ADDR_FUNC_SEL |->
      bus.rdata[7:4] == 4'h0)
      else $error("reserved function bits read nonzero");

   // checks below watch registered state only; pad levels are left to the far side
   // stay-put checks: each register moves only on its own write strobe
   sequence s_no_dir_write;
      !(bus.wr && bus.addr == agp_pkg::AGP_ADDR_DIR_LEVEL);
   endsequence

   sequence s_no_func_write;
      !(bus.wr && bus.addr == agp_pkg::AGP_ADDR_FUNC_SEL);
   endsequence

   // a write aimed at neither pin register
   sequence s_stray_write;
      bus.wr && bus.addr != agp_pkg::AGP_ADDR_DIR_LEVEL
         && bus.addr != agp_pkg::AGP_ADDR_FUNC_SEL;
   endsequence

   // level bits stay put too, so an output never glitches on a function write
   a_dir_level_hold: assert property (s_no_dir_write |=>
      $stable(dir_q) && $stable(gpio_out))
      else $error("direction or level bits moved without a write");

   // routing stays put across level writes
   a_func_hold: assert property (s_no_func_write |=>
      $stable(func_q) && $stable(pin_analog_sel))
      else $error("function bits moved without a write");

   // only the low nibble of a function write is kept; the rest is reserved
   a_func_write_lands: assert property (s_func_write |=>
      func_q == $past(bus.wdata[agp_pkg::AGP_FUNC_LSB +: 4]))
      else $error("function bits did not take the written low nibble");

   // unmapped writes are dropped rather than aliased onto a pin register
   a_stray_write_dropped: assert property (s_stray_write |=>
      $stable(dir_q) && $stable(level_q) && $stable(func_q))
      else $error("write to an unmapped address changed a pin register");

   // an analog pin must never fight the mux with a digital driver
   a_analog_undriven: assert property ((pin_analog_sel & ~gpio_oe_n) == 4'h0)
      else $error("pin driven while routed to the analog mux");

   // an input pin never has its driver on, whatever its function bit
   a_input_undriven: assert property ((dir_q & ~gpio_oe_n) == 4'h0)
      else $error("pin driver on while the pin is set as input");

   a_dir_readback: assert property (bus.addr == agp_pkg::AGP_ADDR_DIR_LEVEL |->
      bus.rdata[7:4] == dir_q)
      else $error("direction bits read back wrong");

   // output pins read back the stored level, not the pad
   a_output_readback: assert property (bus.addr == agp_pkg::AGP_ADDR_DIR_LEVEL |->
      ((bus.rdata[3:0] ^ level_q) & ~dir_q) == 4'h0)
      else $error("output pin read does not show the stored level");

   // serial driver off and every pin analog straight after reset,
   // so nothing on the pads is driven before the host has configured them
   a_reset_quiet: assert property (@(posedge sys_clk) disable iff (1'b0)
      !rst_n |=> pin_analog_sel == agp_pkg::AGP_RST_ANALOG && spi_miso_oe_n && !spi_miso)
      else $error("pins or serial output not quiet after reset");
endmodule
`default_nettype wire

// ===== src/agp_pkg.sv
// constants and types shared by the general-purpose pin port
package agp_pkg;
   typedef logic [7:0] agp_byte_t;
   typedef logic [6:0] agp_addr_t;
   // register addresses carried in the low seven bits of the command byte
   localparam agp_addr_t AGP_ADDR_DIR_LEVEL = 7'h10;
   localparam agp_addr_t AGP_ADDR_FUNC_SEL = 7'h11;
   // values after reset
   localparam logic [3:0] AGP_RST_DIR = 4'h0;
   localparam logic [3:0] AGP_RST_LEVEL = 4'h0;
   localparam logic [3:0] AGP_RST_FUNC = 4'h0;
   localparam logic [3:0] AGP_RST_OE_N = 4'hF;
   localparam logic [3:0] AGP_RST_ANALOG = 4'hF;
   localparam logic [3:0] AGP_RSVD_READ = 4'h0;
   localparam agp_byte_t AGP_UNMAPPED_READ = 8'h00;
   // sync chain reset, ordered {sclk, cs_n, mosi, pins[3:0]}
   localparam logic [6:0] AGP_SYNC_RST = 7'h20;
   // field positions
   localparam int AGP_DIR_LSB = 4;
   localparam int AGP_LEVEL_LSB = 0;
   localparam int AGP_FUNC_LSB = 0;
   localparam int AGP_CMD_RD_BIT = 7;
   // frame shape in serial clock falling edges
   localparam logic [4:0] AGP_CMD_LAST = 5'h08;
   localparam logic [4:0] AGP_FRAME_LAST = 5'h10;
endpackage

// ===== src/agp_reg_if.sv
// register access path between the serial engine and the register file
`timescale 1ns/1ps
`default_nettype none
interface agp_reg_if;
   agp_pkg::agp_addr_t addr;
   agp_pkg::agp_byte_t wdata;
   logic wr;
   agp_pkg::agp_byte_t rdata;
   modport eng (output addr, output wdata, output wr, input rdata);
   modport regs (input addr, input wdata, input wr, output rdata);
endinterface
`default_nettype wire

// ===== src/agp_spi_engine.sv
// serial frame engine: mode 1 shifting, command decode, write strobe and read reply shifting
`timescale 1ns/1ps
`default_nettype none
module agp_spi_engine (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sclk_s,
   input wire logic cs_n_s,
   input wire logic mosi_s,
   output logic miso,
   output logic miso_oe_n,
   agp_reg_if.eng bus
);
   logic sclk_prev_q, sclk_prev_d;
   logic [4:0] cnt_q, cnt_d;
   agp_pkg::agp_byte_t rx_q, rx_d, cmd_q, cmd_d, tx_q, tx_d, wdata_q, wdata_d;
   logic miso_q, miso_d, oe_n_q, oe_n_d, wr_q, wr_d;
   logic rise, fall;
   agp_pkg::agp_byte_t rx_next;

   // edges come from the second sync stage and its delayed copy only
   assign rise = sclk_s & ~sclk_prev_q;
   assign fall = ~sclk_s & sclk_prev_q;
   assign rx_next = {rx_q[6:0], mosi_s};

   // frame sequencing; data is sampled on falls and launched on rises
   always_comb begin
      sclk_prev_d = sclk_s;
      cnt_d = cnt_q;
      rx_d = rx_q;
      cmd_d = cmd_q;
      tx_d = tx_q;
      miso_d = miso_q;
      wdata_d = wdata_q;
      wr_d = 1'b0;
      oe_n_d = cs_n_s;
      if (cs_n_s) begin
         // deselect aborts any partial frame; nothing is written
         cnt_d = 5'h00;
         miso_d = 1'b0;
      end else begin
         if (fall && cnt_q != agp_pkg::AGP_FRAME_LAST) begin
            rx_d = rx_next;
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == agp_pkg::AGP_CMD_LAST - 5'h01) begin
               cmd_d = rx_next;
            end
            if (cnt_q == agp_pkg::AGP_FRAME_LAST - 5'h01 && !cmd_q[agp_pkg::AGP_CMD_RD_BIT]) begin
               wr_d = 1'b1;
               wdata_d = rx_next;
            end
         end
         // reply byte: first bit loaded straight from the register view
         if (rise && cnt_q == agp_pkg::AGP_CMD_LAST && cmd_q[agp_pkg::AGP_CMD_RD_BIT]) begin
            miso_d = bus.rdata[7];
            tx_d = {bus.rdata[6:0], 1'b0};
         end else if (rise && cnt_q > agp_pkg::AGP_CMD_LAST && cmd_q[agp_pkg::AGP_CMD_RD_BIT]) begin
            miso_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sclk_prev_q <= 1'b0;
         cnt_q <= 5'h00;
         rx_q <= 8'h00;
         cmd_q <= 8'h00;
         tx_q <= 8'h00;
         miso_q <= 1'b0;
         wdata_q <= 8'h00;
         wr_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_prev_d;
         cnt_q <= cnt_d;
         rx_q <= rx_d;
         cmd_q <= cmd_d;
         tx_q <= tx_d;
         miso_q <= miso_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign miso = miso_q;
   assign miso_oe_n = oe_n_q;
   assign bus.addr = cmd_q[6:0];
   assign bus.wdata = wdata_q;
   assign bus.wr = wr_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // outgoing bit only moves one cycle after a rising serial edge
   a_miso_rise_launch: assert property ($changed(miso_q) && !$past(cs_n_s) |-> $past(rise))
      else $error("miso changed without a rising serial clock edge");
   // write strobe only after the sixteenth falling edge of a write frame
   a_write_frame_end: assert property (wr_q |-> cnt_q == agp_pkg::AGP_FRAME_LAST && !cmd_q[7])
      else $error("write strobe outside the end of a write frame");
endmodule
`default_nettype wire

// ===== bench/agp_pin_model.sv
// external circuit on the four pins: reads back driven pins, else a bench-chosen level
`timescale 1ns/1ps
`default_nettype none
module agp_pin_model (
   input wire logic [3:0] gpio_out,
   input wire logic [3:0] gpio_oe_n,
   input wire logic [3:0] ext_level,
   output logic [3:0] gpio_in
);
   // a driven pin wins over the outside source, as on a real wire
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         gpio_in[i] = gpio_oe_n[i] ? ext_level[i] : gpio_out[i];
      end
   end
endmodule
`default_nettype wire

// ===== bench/test_adc_gpio_port.sv
// self-checking bench for the pin port: serial host, pin model, random configs
`timescale 1ns/1ps
`default_nettype none
module test_adc_gpio_port;
   logic sys_clk, rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
   logic [3:0] gpio_in, gpio_out, gpio_oe_n, pin_analog_sel, ext, func, dir, lvl;
   logic [7:0] v;
   logic [31:0] lf;
   int num_errors, tests_run;
   agp_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
      .pin_analog_sel(pin_analog_sel));
   agp_pin_model u_pins (.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .ext_level(ext),
      .gpio_in(gpio_in));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected level read: digital inputs show the pin, the rest the stored bit
   function automatic logic [3:0] exp_lvl(input logic [3:0] f, d, l, e);
      return ((f & d) & e) | (~(f & d) & l);
   endfunction
   task automatic check(input agp_pkg::agp_byte_t seen, input agp_pkg::agp_byte_t exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // mode 1 host: mosi changes with the rise, miso taken at the fall
   task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input int nb,
      output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, dat};
      rd = 8'h00;
      @(posedge sys_clk) spi_cs_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < nb; i++) begin
         @(posedge sys_clk) spi_sclk <= 1'b1;
         spi_mosi <= sh[15-i];
         repeat (6) @(posedge sys_clk);
         rd = {rd[6:0], spi_miso};
         spi_sclk <= 1'b0;
         repeat (6) @(posedge sys_clk);
      end
      check({7'h00, spi_miso_oe_n}, 8'h00);
      spi_cs_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
      check({7'h00, spi_miso_oe_n}, 8'h01);
   endtask
   task automatic wr(input agp_pkg::agp_addr_t a, input logic [7:0] d, input int nb);
      frame({1'b0, a}, d, nb, v);
   endtask
   task automatic rd(input agp_pkg::agp_addr_t a, output logic [7:0] d);
      frame({1'b1, a}, 8'h00, 16, d);
   endtask
   task automatic results;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // watchdog: some 53 frames of about 220 cycles each fit well inside this span
   initial begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      results();
   end
   initial begin
      rst_n = 1'b0;
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      ext = 4'h0;
      num_errors = 0;
      tests_run = 0;
      lf = 32'h0000AD61;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check({4'h0, gpio_oe_n}, 8'h0F);
      check({4'h0, pin_analog_sel}, 8'h0F);
      check({4'h0, gpio_out}, 8'h00);
      check({6'h00, spi_miso_oe_n, spi_miso}, 8'h02);
      rd(agp_pkg::AGP_ADDR_DIR_LEVEL, v);
      check(v, 8'h00);
      rd(agp_pkg::AGP_ADDR_FUNC_SEL, v);
      check(v, 8'h00);
      // one-hot function bits first, then random settings
      for (int k = 0; k < 12; k++) begin
         lf = lfsr(lf);
         func = (k < 4) ? (4'h1 << k) : lf[3:0];
         dir = lf[7:4];
         lvl = lf[11:8];
         @(posedge sys_clk) ext <= lf[15:12];
         wr(agp_pkg::AGP_ADDR_FUNC_SEL, {4'h0, func}, 16);
         wr(agp_pkg::AGP_ADDR_DIR_LEVEL, {dir, lvl}, 16);
         check({4'h0, pin_analog_sel}, {4'h0, ~func});
         check({4'h0, gpio_oe_n}, {4'h0, ~(func & ~dir)});
         check({4'h0, gpio_out}, {4'h0, lvl});
         rd(agp_pkg::AGP_ADDR_FUNC_SEL, v);
         check(v, {4'h0, func});
         rd(agp_pkg::AGP_ADDR_DIR_LEVEL, v);
         check(v, {dir, exp_lvl(func, dir, lvl, ext)});
      end
      // a frame cut short writes nothing; an unmapped place ignores writes, reads zero
      wr(agp_pkg::AGP_ADDR_DIR_LEVEL, ~{dir, lvl}, 12);
      check({4'h0, gpio_out}, {4'h0, lvl});
      wr(7'h12, 8'hFF, 16);
      check({pin_analog_sel, gpio_oe_n}, {~func, ~(func & ~dir)});
      check({4'h0, gpio_out}, {4'h0, lvl});
      rd(7'h12, v);
      check(v, 8'h00);
      results();
   end
endmodule
`default_nettype wire
